// ---- hw/msx_exec.sv ----
// Notes on behaviour
// - Decode opcode 101110 plus four-bit immediate.
// - Swap accumulator with nibble at memory pointer.
// - File pointer becomes old value XOR immediate.
// - Increment variant adds one, wrapping modulo sixteen.
// - Increment result zero skips the next instruction.
// - Decrement variant swaps, XORs, subtracts one.
// - Decrement result fifteen skips the next instruction.
`timescale 1ns/1ps
`default_nettype none

module msx_exec #(
    parameter int MPTR_W = 7
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Instruction from the fetch stage, one pulse per instruction.
    input wire logic instr_valid,
    input wire logic [9:0] instr_word,
    // Current register and RAM contents.
    input wire logic [3:0] acc_in,
    input wire logic [3:0] file_ptr_in,
    input wire logic [3:0] word_ptr_in,
    input wire logic [MPTR_W-1:0] memory_pointer,
    input wire logic [3:0] ram_rdata,
    // Register write-back.
    output logic acc_wr_r,
    output logic [3:0] acc_wdata_r,
    output logic file_ptr_wr_r,
    output logic [3:0] file_ptr_wdata_r,
    output logic word_ptr_wr_r,
    output logic [3:0] word_ptr_wdata_r,
    // RAM write-back.
    output logic ram_wr_r,
    output logic [MPTR_W-1:0] ram_addr_r,
    output logic [3:0] ram_wdata_r,
    // Sequencing towards the rest of the core.
    output logic op_hit,
    output logic squash,
    output logic skip_pending
);

    // The data path is a nibble machine; other widths cannot be served.
    if (msx_pkg::NIB_W != 4 || msx_pkg::WORD_W != 10) begin : g_width_check
        $error("msx_exec supports only a 4-bit data path and 10-bit words");
    end
    if (MPTR_W < 1) begin : g_mptr_check
        $error("msx_exec needs a memory pointer of at least one bit");
    end
    if (msx_pkg::OPC_W != 6) begin : g_opc_w_check
        $error("msx_exec decodes a six-bit opcode field only");
    end
    if (msx_pkg::OPC_LSB + msx_pkg::OPC_W != msx_pkg::WORD_W) begin : g_opc_check
        $error("msx_exec needs the opcode field at the top of the word");
    end
    if (msx_pkg::IMM_LSB + msx_pkg::NIB_W > msx_pkg::OPC_LSB) begin : g_imm_check
        $error("msx_exec needs the immediate field below the opcode field");
    end
    if (msx_pkg::OPC_SWAP_INC == msx_pkg::OPC_SWAP_DEC) begin : g_code_check
        $error("msx_exec needs distinct codes for the two swap instructions");
    end

    // Opcode match, used for both swap instructions.
    function automatic logic opc_is(input logic [9:0] word, input logic [5:0] code);
        opc_is = (word[msx_pkg::OPC_LSB +: msx_pkg::OPC_W] == code);
    endfunction

    // Word pointer after one step in either direction, modulo sixteen.
    function automatic logic [3:0] step_ptr(input logic [3:0] ptr, input logic down);
        if (down) begin
            step_ptr = 4'(ptr - msx_pkg::STEP_ONE);
        end else begin
            step_ptr = 4'(ptr + msx_pkg::STEP_ONE);
        end
    endfunction

    // Skip decision: the stepped pointer has landed on the wrap value of its direction.
    function automatic logic wraps_to(input logic [3:0] ptr, input logic [3:0] wrap);
        wraps_to = (ptr == wrap);
    endfunction

    msx_pkg::msx_state_type state_r;
    msx_pkg::msx_state_type state_nxt;
    logic is_inc;
    logic is_dec;
    logic exec_go;
    logic [3:0] imm;
    logic [3:0] word_ptr_nxt;
    logic skip_nxt;

    assign is_inc = opc_is(instr_word, msx_pkg::OPC_SWAP_INC);
    assign is_dec = opc_is(instr_word, msx_pkg::OPC_SWAP_DEC);
    assign imm = instr_word[msx_pkg::IMM_LSB +: msx_pkg::NIB_W];

    // A fetched instruction in the skip state is dropped whole.
    assign squash = instr_valid && (state_r == msx_pkg::ST_SKIP);
    assign exec_go = instr_valid && !squash && (is_inc || is_dec);
    assign op_hit = exec_go;
    assign skip_pending = (state_r == msx_pkg::ST_SKIP);

    // New word pointer and the skip decision for this instruction.
    always_comb begin
        word_ptr_nxt = word_ptr_in;
        skip_nxt = 1'b0;
        if (is_inc) begin
            word_ptr_nxt = step_ptr(word_ptr_in, 1'b0);
            skip_nxt = wraps_to(word_ptr_nxt, msx_pkg::WRAP_INC);
        end else if (is_dec) begin
            word_ptr_nxt = step_ptr(word_ptr_in, 1'b1);
            skip_nxt = wraps_to(word_ptr_nxt, msx_pkg::WRAP_DEC);
        end
    end

    // Sequencer. Any valid instruction in the skip state clears the pending skip, so a
    // skip never reaches past the single instruction that follows.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            msx_pkg::ST_RUN: begin
                if (exec_go && skip_nxt) begin
                    state_nxt = msx_pkg::ST_SKIP;
                end
            end
            msx_pkg::ST_SKIP: begin
                if (instr_valid) begin
                    state_nxt = msx_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = msx_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= msx_pkg::ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Write strobes last one cycle. Write-back lands one cycle after the
    // instruction, so instructions must be at least two cycles apart; the
    // instruction enable of the core is far slower than that.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_wr_r <= 1'b0;
        end else begin
            acc_wr_r <= exec_go;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            file_ptr_wr_r <= 1'b0;
        end else begin
            file_ptr_wr_r <= exec_go;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            word_ptr_wr_r <= 1'b0;
        end else begin
            word_ptr_wr_r <= exec_go;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ram_wr_r <= 1'b0;
        end else begin
            ram_wr_r <= exec_go;
        end
    end

    // Swapped nibbles: memory goes to the accumulator and back.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_wdata_r <= msx_pkg::NIB_RST;
        end else if (exec_go) begin
            acc_wdata_r <= ram_rdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ram_wdata_r <= msx_pkg::NIB_RST;
        end else if (exec_go) begin
            ram_wdata_r <= acc_in;
        end
    end

    // The address is captured with the data so that the write lands on the
    // nibble that was read, even if the pointer moves before write-back.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ram_addr_r <= '0;
        end else if (exec_go) begin
            ram_addr_r <= memory_pointer;
        end
    end

    // Pointer updates.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            file_ptr_wdata_r <= msx_pkg::NIB_RST;
        end else if (exec_go) begin
            file_ptr_wdata_r <= file_ptr_in ^ imm;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            word_ptr_wdata_r <= msx_pkg::NIB_RST;
        end else if (exec_go) begin
            word_ptr_wdata_r <= word_ptr_nxt;
        end
    end

endmodule // msx_exec

`default_nettype wire

// ---- shared/msx_pkg.sv ----
`default_nettype none

package msx_pkg;

    // Widths of the core's data path and instruction word.
    localparam int NIB_W = 4;
    localparam int WORD_W = 10;
    localparam int OPC_W = 6;

    // Opcode field of the two swap instructions, bits 9 down to 4.
    localparam logic [5:0] OPC_SWAP_INC = 6'h2e;
    localparam logic [5:0] OPC_SWAP_DEC = 6'h2f;

    // Position of the opcode and immediate fields in the word.
    localparam int OPC_LSB = 4;
    localparam int IMM_LSB = 0;

    // Word pointer values that raise a skip for each direction.
    localparam logic [3:0] WRAP_INC = 4'h0;
    localparam logic [3:0] WRAP_DEC = 4'hf;
    localparam logic [3:0] STEP_ONE = 4'h1;

    // Reset values of the block's own state.
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic SKIP_RST = 1'b0;

    // Sequencer states: run normally or drop the next instruction.
    typedef enum logic {
        ST_RUN,
        ST_SKIP
    } msx_state_type;

endpackage

`default_nettype wire

// ---- testbench/msx_exec_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module msx_exec_assertions #(
    parameter int MPTR_W = 7
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Instruction side.
    input wire logic instr_valid,
    input wire logic [9:0] instr_word,
    input wire logic [3:0] acc_in,
    input wire logic [3:0] file_ptr_in,
    input wire logic [3:0] word_ptr_in,
    input wire logic [MPTR_W-1:0] memory_pointer,
    input wire logic [3:0] ram_rdata,
    // Write-back side.
    input wire logic acc_wr_r,
    input wire logic [3:0] acc_wdata_r,
    input wire logic file_ptr_wr_r,
    input wire logic [3:0] file_ptr_wdata_r,
    input wire logic word_ptr_wr_r,
    input wire logic [3:0] word_ptr_wdata_r,
    input wire logic ram_wr_r,
    input wire logic [MPTR_W-1:0] ram_addr_r,
    input wire logic [3:0] ram_wdata_r,
    // Sequencing side.
    input wire logic op_hit,
    input wire logic squash,
    input wire logic skip_pending
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic go = instr_valid && !skip_pending && instr_word[9:5] == 5'h17;
    wire logic [3:0] x_nxt = file_ptr_in ^ instr_word[3:0];
    property p_hit; op_hit == go && squash == (instr_valid && skip_pending); endproperty
    a_hit: assert property (p_hit) else $error("swap not decoded");
    property p_swap; op_hit |=> acc_wr_r && ram_wr_r && acc_wdata_r == $past(ram_rdata)
        && ram_wdata_r == $past(acc_in) && ram_addr_r == $past(memory_pointer); endproperty
    a_swap: assert property (p_swap) else $error("bad exchange");
    property p_xor; op_hit |=> file_ptr_wr_r && file_ptr_wdata_r == $past(x_nxt); endproperty
    a_xor: assert property (p_xor) else $error("bad file pointer");
    property p_inc; op_hit && !instr_word[4] |=> word_ptr_wr_r
        && word_ptr_wdata_r == $past(word_ptr_in) + 4'h1; endproperty
    a_inc: assert property (p_inc) else $error("bad increment");
    property p_skip_inc; op_hit && !instr_word[4] |=> skip_pending == (word_ptr_wdata_r == 4'h0); endproperty
    a_skip_inc: assert property (p_skip_inc) else $error("bad skip after increment");
    property p_dec; op_hit && instr_word[4] |=> word_ptr_wr_r
        && word_ptr_wdata_r == $past(word_ptr_in) - 4'h1; endproperty
    a_dec: assert property (p_dec) else $error("bad decrement");
    property p_skip_dec; op_hit && instr_word[4] |=> skip_pending == (word_ptr_wdata_r == 4'hf); endproperty
    a_skip_dec: assert property (p_skip_dec) else $error("bad skip after decrement");
    property p_squash; instr_valid && skip_pending |-> squash && !op_hit ##1
        !acc_wr_r && !ram_wr_r && !file_ptr_wr_r && !word_ptr_wr_r && !skip_pending; endproperty
    a_squash: assert property (p_squash) else $error("skipped word had effect");
endmodule // msx_exec_assertions
bind msx_exec msx_exec_assertions #(.MPTR_W(MPTR_W)) u_chk (
    .clk_sys(clk_sys),
    .rst(rst),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .acc_in(acc_in),
    .file_ptr_in(file_ptr_in),
    .word_ptr_in(word_ptr_in),
    .memory_pointer(memory_pointer),
    .ram_rdata(ram_rdata),
    .acc_wr_r(acc_wr_r),
    .acc_wdata_r(acc_wdata_r),
    .file_ptr_wr_r(file_ptr_wr_r),
    .file_ptr_wdata_r(file_ptr_wdata_r),
    .word_ptr_wr_r(word_ptr_wr_r),
    .word_ptr_wdata_r(word_ptr_wdata_r),
    .ram_wr_r(ram_wr_r),
    .ram_addr_r(ram_addr_r),
    .ram_wdata_r(ram_wdata_r),
    .op_hit(op_hit),
    .squash(squash),
    .skip_pending(skip_pending)
);
`default_nettype wire

// ---- testbench/msx_exec_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module msx_exec_test;
    logic clk_sys = 1'b0, rst = 1'b1, instr_valid = 1'b0, skip = 1'b0;
    logic [9:0] instr_word = 10'h0;
    logic [3:0] acc_in = 4'h0, file_ptr_in = 4'h0, word_ptr_in = 4'h0, ram_rdata = 4'h0, y, ny;
    logic [6:0] memory_pointer = 7'h0, ram_addr_r;
    logic acc_wr_r, file_ptr_wr_r, word_ptr_wr_r, ram_wr_r, op_hit, squash, skip_pending;
    logic [3:0] acc_wdata_r, file_ptr_wdata_r, word_ptr_wdata_r, ram_wdata_r;
    logic [26:0] exp_q[$];
    logic [26:0] e;
    logic [31:0] seed = 32'h7bee0870, r;
    logic [5:0] op;
    int bad_count = 0, samples_checked = 0;
    msx_exec DUT (
        .clk_sys(clk_sys),
        .rst(rst),
        .instr_valid(instr_valid),
        .instr_word(instr_word),
        .acc_in(acc_in),
        .file_ptr_in(file_ptr_in),
        .word_ptr_in(word_ptr_in),
        .memory_pointer(memory_pointer),
        .ram_rdata(ram_rdata),
        .acc_wr_r(acc_wr_r),
        .acc_wdata_r(acc_wdata_r),
        .file_ptr_wr_r(file_ptr_wr_r),
        .file_ptr_wdata_r(file_ptr_wdata_r),
        .word_ptr_wr_r(word_ptr_wr_r),
        .word_ptr_wdata_r(word_ptr_wdata_r),
        .ram_wr_r(ram_wr_r),
        .ram_addr_r(ram_addr_r),
        .ram_wdata_r(ram_wdata_r),
        .op_hit(op_hit),
        .squash(squash),
        .skip_pending(skip_pending)
    );
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial forever #4 clk_sys = ~clk_sys;
    // Boundary word pointers are favoured so that skips, and skipped swaps, come often.
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_sys);
            r = rnd();
            y = (r[31:30] == 2'b00) ? {4{r[29]}} : r[3:0];
            op = (r[10:9] == 2'b00) ? r[27:22] : {5'h17, r[8]};
            instr_valid <= 1'b1;
            instr_word <= {op, r[7:4]};
            acc_in <= r[15:12];
            file_ptr_in <= r[19:16];
            word_ptr_in <= y;
            ram_rdata <= r[23:20];
            memory_pointer <= r[30:24];
            ny = op[0] ? y - 4'h1 : y + 4'h1;
            if (skip) skip = 1'b0;
            else if (op[5:1] == 5'h17) begin
                exp_q.push_back({4'hf, r[30:24], r[23:20], r[15:12], r[19:16] ^ r[7:4], ny});
                skip = (ny == (op[0] ? 4'hf : 4'h0));
            end
            @(posedge clk_sys);
            instr_valid <= 1'b0;
        end
        repeat (3) @(posedge clk_sys);
        samples_checked++;
        if (exp_q.size() != 0) bad_count++;
        wrap_up();
    end
    always @(posedge clk_sys) begin
        if (!rst && (acc_wr_r || ram_wr_r || file_ptr_wr_r || word_ptr_wr_r)) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 27'h0;
            samples_checked++;
            if ({acc_wr_r, file_ptr_wr_r, word_ptr_wr_r, ram_wr_r, ram_addr_r, acc_wdata_r, ram_wdata_r,
                file_ptr_wdata_r, word_ptr_wdata_r} !== e) begin
                bad_count++;
                $display("mismatch t=%0t exp=%h got=%h", $time, e, {acc_wr_r, file_ptr_wr_r, word_ptr_wr_r,
                    ram_wr_r, ram_addr_r, acc_wdata_r, ram_wdata_r, file_ptr_wdata_r, word_ptr_wdata_r});
            end
        end
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        wrap_up();
    end
endmodule // msx_exec_test
`default_nettype wire
